// [sec_pkg.sv]
// Purpose: shared constants and types for the serial eeprom command engine
// Assumes: 40 MHz core clock, microwire-style eeprom in x8 organisation
// Notes: register offsets are byte addresses on the plain register port
package sec_pkg;
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_DATA = 4'h4;
  localparam logic [3:0] REG_INT_STS = 4'h8;
  localparam logic [3:0] REG_INT_MASK = 4'hC;

  localparam int CMD_BUSY_BIT = 31;
  localparam int CMD_CODE_LSB = 28;
  localparam int CMD_TIMEOUT_BIT = 9;
  localparam int CMD_LOADED_BIT = 8;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  localparam int INT_DONE_BIT = 0;
  localparam int INT_TIMEOUT_BIT = 1;
  localparam int INT_LOADED_BIT = 2;
  localparam int INT_W = 3;

  typedef enum logic [2:0] {
    CMD_ERASE_WRITE_DISABLE_CMD = 3'b000,
    CMD_ERASE_WRITE_ENABLE_CMD = 3'b001,
    CMD_WRITE = 3'b010,
    CMD_WRITE_ALL_CMD = 3'b011,
    CMD_ERASE = 3'b100,
    CMD_ERASE_ALL_CMD = 3'b101,
    CMD_RELOAD = 3'b111
  } sec_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SHIFT = 3'b001,
    ST_CSGAP = 3'b010,
    ST_POLL = 3'b011,
    ST_FINISH = 3'b100
  } sec_state_t;

  // serial opcodes and extended-opcode address patterns
  localparam logic [1:0] OP_EXT = 2'b00;
  localparam logic [1:0] OP_WRITE = 2'b01;
  localparam logic [1:0] OP_READ = 2'b10;
  localparam logic [1:0] OP_ERASE = 2'b11;
  localparam logic [7:0] EXT_ERASE_WRITE_DISABLE_CMD = 8'h00;
  localparam logic [7:0] EXT_WRITE_ALL_CMD = 8'h40;
  localparam logic [7:0] EXT_ERASE_ALL_CMD = 8'h80;
  localparam logic [7:0] EXT_ERASE_WRITE_ENABLE_CMD = 8'hC0;

  localparam logic [7:0] SIGNATURE = 8'hA5;
  localparam int FRAME_BITS = 11;
  localparam int WR_FRAME_BITS = 19;
  localparam int RELOAD_BITS = 67;

  localparam int CLK_MHZ = 40;
  localparam int TIMEOUT_US = 30000;
  localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
  localparam int SCK_HALF = 4;
  localparam int TCS_NS = 250;
  localparam int TCS_CYC = (TCS_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_STAGES = 2;

  typedef struct packed {
    logic cs;
    logic sck;
    logic dout;
    logic oe;
  } sec_pins_t;
endpackage : sec_pkg

// [sec_engine.sv]
// Purpose: runs host commands on an external serial eeprom and reloads the station address
// Assumes: register port strobes are one cycle; eeprom data pin is external, sampled through two flops
// Notes: a station address reload runs by itself after reset
//
// The address map and the strobed register port were left to the implementer.
module sec_engine #(
  parameter int TIMEOUT_CYCLES = sec_pkg::TIMEOUT_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_eedio_in,
  output sec_pkg::sec_pins_t o_eep,
  output logic o_busy,
  output logic [47:0] o_station_addr,
  output logic o_station_addr_loaded,
  output logic o_irq
);
  sec_pkg::sec_state_t state_ff, nxt_state;
  logic din_meta_ff, din_sync_ff;
  logic boot_pend_ff, nxt_boot_pend;
  logic [7:0] byte_addr_ff, nxt_byte_addr;
  logic [7:0] byte_data_ff, nxt_byte_data;
  logic timeout_flag_ff, nxt_timeout_flag;
  logic loaded_flag_ff, nxt_loaded_flag;
  logic [sec_pkg::INT_W-1:0] int_sts_ff, nxt_int_sts;
  logic [sec_pkg::INT_W-1:0] int_mask_ff, nxt_int_mask;
  logic [18:0] tx_ff, nxt_tx;
  logic [55:0] rx_ff, nxt_rx;
  logic [6:0] bit_cnt_ff, nxt_bit_cnt;
  logic [6:0] nbits_ff, nxt_nbits;
  logic prog_ff, nxt_prog;
  logic reload_ff, nxt_reload;
  logic [7:0] div_ff, nxt_div;
  logic [20:0] tmo_ff, nxt_tmo;
  sec_pkg::sec_pins_t pins_ff, nxt_pins;
  logic [47:0] station_ff, nxt_station;
  logic [31:0] rdata_ff, nxt_rdata;
  logic start;
  logic [2:0] start_code;

  // eeprom data pin comes from outside; two flops before any use
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      din_meta_ff <= 1'b0;
      din_sync_ff <= 1'b0;
    end else begin
      din_meta_ff <= i_eedio_in;
      din_sync_ff <= din_meta_ff;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_boot_pend = boot_pend_ff;
    nxt_byte_addr = byte_addr_ff;
    nxt_byte_data = byte_data_ff;
    nxt_timeout_flag = timeout_flag_ff;
    nxt_loaded_flag = loaded_flag_ff;
    nxt_int_sts = int_sts_ff;
    nxt_int_mask = int_mask_ff;
    nxt_tx = tx_ff;
    nxt_rx = rx_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_nbits = nbits_ff;
    nxt_prog = prog_ff;
    nxt_reload = reload_ff;
    nxt_div = div_ff;
    nxt_tmo = tmo_ff;
    nxt_pins = pins_ff;
    nxt_station = station_ff;
    nxt_rdata = 32'h0000_0000;
    start = 1'b0;
    start_code = i_wdata[sec_pkg::CMD_CODE_LSB +: 3];

    if (i_rd) begin
      case (i_addr)
        sec_pkg::REG_CMD: begin
          nxt_rdata[sec_pkg::CMD_BUSY_BIT] = o_busy;
          nxt_rdata[sec_pkg::CMD_TIMEOUT_BIT] = timeout_flag_ff;
          nxt_rdata[sec_pkg::CMD_LOADED_BIT] = loaded_flag_ff;
          nxt_rdata[7:0] = byte_addr_ff;
        end
        sec_pkg::REG_DATA: nxt_rdata[7:0] = byte_data_ff;
        sec_pkg::REG_INT_STS: nxt_rdata[sec_pkg::INT_W-1:0] = int_sts_ff;
        sec_pkg::REG_INT_MASK: nxt_rdata[sec_pkg::INT_W-1:0] = int_mask_ff;
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end

    // clears come first so that a same-cycle hardware set wins
    if (i_wr) begin
      case (i_addr)
        sec_pkg::REG_CMD: begin
          if (i_wdata[sec_pkg::CMD_TIMEOUT_BIT]) begin
            nxt_timeout_flag = 1'b0;
          end
          if (!o_busy) begin
            nxt_byte_addr = i_wdata[7:0];
            start = i_wdata[sec_pkg::CMD_BUSY_BIT];
          end
        end
        sec_pkg::REG_DATA: begin
          if (!o_busy) begin
            nxt_byte_data = i_wdata[7:0];
          end
        end
        sec_pkg::REG_INT_STS: nxt_int_sts = int_sts_ff & ~i_wdata[sec_pkg::INT_W-1:0];
        sec_pkg::REG_INT_MASK: nxt_int_mask = i_wdata[sec_pkg::INT_W-1:0];
        default: nxt_int_mask = int_mask_ff;
      endcase
    end

    if (boot_pend_ff && state_ff == sec_pkg::ST_IDLE) begin
      start = 1'b1;
      start_code = sec_pkg::CMD_RELOAD;
      nxt_boot_pend = 1'b0;
    end

    if (start) begin
      nxt_state = sec_pkg::ST_SHIFT;
      nxt_bit_cnt = 7'h00;
      nxt_div = 8'h00;
      nxt_prog = 1'b1;
      nxt_reload = 1'b0;
      nxt_nbits = 7'(sec_pkg::FRAME_BITS);
      nxt_pins = '{cs: 1'b1, sck: 1'b0, dout: 1'b0, oe: 1'b1};
      case (start_code)
        sec_pkg::CMD_ERASE_WRITE_DISABLE_CMD: begin
          nxt_tx = {1'b1, sec_pkg::OP_EXT, sec_pkg::EXT_ERASE_WRITE_DISABLE_CMD, 8'h00};
          nxt_prog = 1'b0;
        end
        sec_pkg::CMD_ERASE_WRITE_ENABLE_CMD: begin
          nxt_tx = {1'b1, sec_pkg::OP_EXT, sec_pkg::EXT_ERASE_WRITE_ENABLE_CMD, 8'h00};
          nxt_prog = 1'b0;
        end
        sec_pkg::CMD_WRITE: begin
          nxt_tx = {1'b1, sec_pkg::OP_WRITE, nxt_byte_addr, byte_data_ff};
          nxt_nbits = 7'(sec_pkg::WR_FRAME_BITS);
        end
        sec_pkg::CMD_WRITE_ALL_CMD: begin
          nxt_tx = {1'b1, sec_pkg::OP_EXT, sec_pkg::EXT_WRITE_ALL_CMD, byte_data_ff};
          nxt_nbits = 7'(sec_pkg::WR_FRAME_BITS);
        end
        sec_pkg::CMD_ERASE: nxt_tx = {1'b1, sec_pkg::OP_ERASE, nxt_byte_addr, 8'h00};
        sec_pkg::CMD_ERASE_ALL_CMD: nxt_tx = {1'b1, sec_pkg::OP_EXT, sec_pkg::EXT_ERASE_ALL_CMD, 8'h00};
        sec_pkg::CMD_RELOAD: begin
          nxt_tx = {1'b1, sec_pkg::OP_READ, 8'h00, 8'h00};
          nxt_nbits = 7'(sec_pkg::RELOAD_BITS);
          nxt_prog = 1'b0;
          nxt_reload = 1'b1;
          nxt_loaded_flag = 1'b0;
        end
        default: begin
          nxt_state = sec_pkg::ST_IDLE;
          nxt_pins = pins_ff;
        end
      endcase
    end else begin
      case (state_ff)
        sec_pkg::ST_SHIFT: begin
          nxt_div = div_ff + 8'h01;
          nxt_pins.dout = tx_ff[18];
          // release the data pin once the read data starts
          nxt_pins.oe = !(reload_ff && bit_cnt_ff >= 7'(sec_pkg::FRAME_BITS));
          nxt_pins.sck = (div_ff >= 8'(sec_pkg::SCK_HALF - 1)) && (div_ff < 8'(2 * sec_pkg::SCK_HALF - 1));
          if (div_ff == 8'(2 * sec_pkg::SCK_HALF - 1)) begin
            nxt_div = 8'h00;
            nxt_pins.sck = 1'b0;
            nxt_rx = {rx_ff[54:0], din_sync_ff};
            nxt_tx = {tx_ff[17:0], 1'b0};
            nxt_bit_cnt = bit_cnt_ff + 7'h01;
            if (reload_ff && bit_cnt_ff == 7'(sec_pkg::FRAME_BITS - 1)) begin
              nxt_pins.oe = 1'b0;
            end
            if (bit_cnt_ff == nbits_ff - 7'h01) begin
              nxt_pins.cs = 1'b0;
              nxt_pins.oe = 1'b0;
              nxt_state = prog_ff ? sec_pkg::ST_CSGAP : sec_pkg::ST_FINISH;
            end
          end
        end
        // cs low gap between frame and ready poll
        sec_pkg::ST_CSGAP: begin
          nxt_div = div_ff + 8'h01;
          if (div_ff == 8'(sec_pkg::TCS_CYC - 1)) begin
            nxt_pins.cs = 1'b1;
            // ready timer counts only the poll
            nxt_tmo = 21'h00_0000;
            nxt_state = sec_pkg::ST_POLL;
          end
        end
        sec_pkg::ST_POLL: begin
          nxt_tmo = tmo_ff + 21'h00_0001;
          // first synced samples after cs rises still show the released line
          if (din_sync_ff && tmo_ff >= 21'(sec_pkg::SYNC_STAGES)) begin
            nxt_pins.cs = 1'b0;
            nxt_state = sec_pkg::ST_FINISH;
          end else if (tmo_ff == 21'(TIMEOUT_CYCLES - 1)) begin
            // abandon without the done bit
            nxt_pins.cs = 1'b0;
            nxt_timeout_flag = 1'b1;
            nxt_int_sts[sec_pkg::INT_TIMEOUT_BIT] = 1'b1;
            nxt_state = sec_pkg::ST_IDLE;
          end
        end
        sec_pkg::ST_FINISH: begin
          nxt_state = sec_pkg::ST_IDLE;
          nxt_int_sts[sec_pkg::INT_DONE_BIT] = 1'b1;
          if (reload_ff && rx_ff[55:48] == sec_pkg::SIGNATURE) begin
            nxt_station = {rx_ff[7:0], rx_ff[15:8], rx_ff[23:16], rx_ff[31:24], rx_ff[39:32], rx_ff[47:40]};
            nxt_loaded_flag = 1'b1;
            nxt_int_sts[sec_pkg::INT_LOADED_BIT] = 1'b1;
          end
        end
        default: nxt_state = sec_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff <= sec_pkg::ST_IDLE;
      boot_pend_ff <= 1'b1;
      byte_addr_ff <= sec_pkg::ADDR_RESET;
      byte_data_ff <= sec_pkg::DATA_RESET;
      timeout_flag_ff <= 1'b0;
      loaded_flag_ff <= 1'b0;
      int_sts_ff <= '0;
      int_mask_ff <= '0;
      tx_ff <= '0;
      rx_ff <= '0;
      bit_cnt_ff <= '0;
      nbits_ff <= '0;
      prog_ff <= 1'b0;
      reload_ff <= 1'b0;
      div_ff <= '0;
      tmo_ff <= '0;
      pins_ff <= '0;
      station_ff <= '0;
      rdata_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      boot_pend_ff <= nxt_boot_pend;
      byte_addr_ff <= nxt_byte_addr;
      byte_data_ff <= nxt_byte_data;
      timeout_flag_ff <= nxt_timeout_flag;
      loaded_flag_ff <= nxt_loaded_flag;
      int_sts_ff <= nxt_int_sts;
      int_mask_ff <= nxt_int_mask;
      tx_ff <= nxt_tx;
      rx_ff <= nxt_rx;
      bit_cnt_ff <= nxt_bit_cnt;
      nbits_ff <= nxt_nbits;
      prog_ff <= nxt_prog;
      reload_ff <= nxt_reload;
      div_ff <= nxt_div;
      tmo_ff <= nxt_tmo;
      pins_ff <= nxt_pins;
      station_ff <= nxt_station;
      rdata_ff <= nxt_rdata;
    end
  end

  // busy covers the pending boot reload so host commands wait for it
  assign o_busy = (state_ff != sec_pkg::ST_IDLE) || boot_pend_ff;
  assign o_rdata = rdata_ff;
  assign o_eep = pins_ff;
  assign o_station_addr = station_ff;
  assign o_station_addr_loaded = loaded_flag_ff;
  assign o_irq = |(int_sts_ff & int_mask_ff);
endmodule : sec_engine

// [sec_engine_properties.sv]
// Purpose: port checks for the eeprom command engine
// Assumes: one clock domain, async active-low reset
// Notes: shadows track the byte and address fields
module sec_engine_properties #(
  parameter int TIMEOUT_CYCLES = 200
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic i_eedio_in,
  input wire sec_pkg::sec_pins_t o_eep,
  input wire logic o_busy,
  input wire logic [47:0] o_station_addr,
  input wire logic o_station_addr_loaded,
  input wire logic o_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  logic [7:0] data_sh_ff;
  logic [7:0] nxt_data_sh;
  logic [7:0] addr_sh_ff;
  logic [7:0] nxt_addr_sh;
  int busy_cnt_ff;
  int nxt_busy_cnt;
  always_comb begin
    nxt_data_sh = data_sh_ff;
    nxt_addr_sh = addr_sh_ff;
    nxt_busy_cnt = o_busy ? busy_cnt_ff + 1 : 0;
    if (i_wr && !o_busy && i_addr == sec_pkg::REG_DATA) nxt_data_sh = i_wdata[7:0];
    if (i_wr && !o_busy && i_addr == sec_pkg::REG_CMD) nxt_addr_sh = i_wdata[7:0];
  end
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      data_sh_ff <= 8'h00;
      addr_sh_ff <= 8'h00;
      busy_cnt_ff <= 0;
    end else begin
      data_sh_ff <= nxt_data_sh;
      addr_sh_ff <= nxt_addr_sh;
      busy_cnt_ff <= nxt_busy_cnt;
    end
  end
  sequence start_req_s;
    i_wr && i_addr == sec_pkg::REG_CMD && i_wdata[31] && i_wdata[30:28] != 3'h6 && !o_busy;
  endsequence
  sequence sck_pulse_s;
    o_eep.sck [*4] ##1 !o_eep.sck;
  endsequence
  cmd_start_a: assert property (start_req_s |=> o_busy && o_eep.cs && o_eep.oe ##1 o_eep.dout)
    else $error("command did not start a frame");
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data not zero outside read");
  data_readback_a: assert property (i_rd && i_addr == sec_pkg::REG_DATA |=> o_rdata == {24'h0, data_sh_ff})
    else $error("byte register read mismatch");
  addr_readback_a: assert property (i_rd && i_addr == sec_pkg::REG_CMD |=> o_rdata[7:0] == addr_sh_ff)
    else $error("address field read mismatch");
  busy_bound_a: assert property (busy_cnt_ff < TIMEOUT_CYCLES + 600)
    else $error("command not abandoned in time");
  sck_in_frame_a: assert property (o_eep.sck |-> o_eep.cs)
    else $error("serial clock outside frame");
  oe_in_frame_a: assert property (o_eep.oe |-> o_eep.cs && o_busy)
    else $error("data driven outside frame");
  sck_width_a: assert property ($rose(o_eep.sck) |-> sck_pulse_s)
    else $error("serial clock high time wrong");
  loaded_stable_a: assert property (!o_busy && !$past(o_busy) |-> $stable(o_station_addr_loaded))
    else $error("loaded flag moved while idle");
  station_stable_a: assert property (!o_busy && !$past(o_busy) |-> $stable(o_station_addr))
    else $error("station address moved while idle");
endmodule : sec_engine_properties
bind sec_engine sec_engine_properties #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_props (
  .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_eedio_in(i_eedio_in), .o_eep(o_eep),
  .o_busy(o_busy), .o_station_addr(o_station_addr),
  .o_station_addr_loaded(o_station_addr_loaded), .o_irq(o_irq));

// [sec_eeprom_model.sv]
// Purpose: behavioural serial eeprom, 256 bytes
// Assumes: frames clocked on rising serial clock edges
// Notes: a released data line shows the inverse of its last value
module sec_eeprom_model (
  input wire logic i_cs,
  input wire logic i_sck,
  input wire logic i_din,
  input wire logic i_slow,
  input wire logic i_stuck,
  output logic o_dio
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [18:0] sr = 19'h0;
  logic [1:0] op;
  logic [7:0] a;
  logic [7:0] d;
  logic [7:0] ra;
  logic ew_en = 1'b0;
  logic pend = 1'b0;
  logic rd_on = 1'b0;
  int n = 0;
  initial o_dio = 1'b0;
  always @(posedge i_cs) begin
    n = 0;
    if (pend) begin
      o_dio = 1'b0;
      if (!i_stuck) o_dio <= #(i_slow ? 3000 : 100) 1'b1;
    end
  end
  always @(posedge i_sck) if (i_cs) begin
    sr = {sr[17:0], i_din};
    n = n + 1;
    if (n == 11) rd_on = sr[10:8] == 3'b110;
    if (n == 11) ra = sr[7:0];
  end
  always @(negedge i_sck) if (i_cs && rd_on) o_dio = mem[8'(ra + (n - 11) / 8)][7 - (n - 11) % 8];
  always @(negedge i_cs) begin
    rd_on = 1'b0;
    pend = 1'b0;
    {op, a, d} = (n == 19) ? sr[17:0] : {sr[9:0], 8'h00};
    if ((n == 11 || n == 19) && sr[n - 1]) begin
      if (op == 2'b00 && a[7:6] == 2'b11) ew_en = 1'b1;
      if (op == 2'b00 && a[7:6] == 2'b00) ew_en = 1'b0;
      pend = ew_en && (op[0] || (op == 2'b00 && a[7] != a[6]));
      for (int i = 0; i < 256; i++) begin
        if (pend && (op == 2'b00 || i == int'(a))) mem[i] = (op == 2'b11 || (op == 2'b00 && a[7])) ? 8'hFF : d;
      end
    end
    o_dio = ~o_dio;
  end
endmodule : sec_eeprom_model

// [test_sec_engine.sv]
// Purpose: register-level test of the eeprom command engine
// Assumes: 40 MHz clock, ready timeout shortened to 200 cycles
// Notes: the model holds a signature and station address at start
module test_sec_engine;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  sec_pkg::sec_pins_t o_eep;
  logic o_busy;
  logic [47:0] o_station_addr;
  logic o_station_addr_loaded;
  logic o_irq;
  logic m_dio;
  logic eedio;
  logic slow = 1'b0;
  logic stuck = 1'b0;
  int n_fail = 0;
  int checks = 0;
  assign eedio = o_eep.oe ? o_eep.dout : m_dio;
  always #12.5 i_core_clk = ~i_core_clk;
  sec_engine #(.TIMEOUT_CYCLES(200)) u_dut (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_eedio_in(eedio), .o_eep(o_eep), .o_busy(o_busy), .o_station_addr(o_station_addr),
    .o_station_addr_loaded(o_station_addr_loaded), .o_irq(o_irq));
  sec_eeprom_model u_mem (.i_cs(o_eep.cs), .i_sck(o_eep.sck), .i_din(eedio),
    .i_slow(slow), .i_stuck(stuck), .o_dio(m_dio));
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input string what, input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1;
    chk(what, 48'(exp & m), 48'(o_rdata & m));
  endtask : rd
  task automatic idle();
    int i;
    #1;
    for (i = 0; i < 2000 && o_busy !== 1'b0; i++) @(posedge i_core_clk);
    if (i == 2000) begin
      chk("busy", 48'h0, 48'(o_busy));
      test_done();
    end
  endtask : idle
  task automatic cmd(input logic [2:0] c, input logic [7:0] a);
    wr(sec_pkg::REG_CMD, {1'b1, c, 20'h0, a});
    idle();
  endtask : cmd
  initial begin
    for (int i = 0; i < 256; i++) u_mem.mem[i] = 8'(i);
    u_mem.mem[0] = sec_pkg::SIGNATURE;
    repeat (10) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    idle();
    chk("loaded", 48'h1, 48'(o_station_addr_loaded));
    chk("station", 48'h060504030201, o_station_addr);
    rd("cmd", sec_pkg::REG_CMD, 32'h100, 32'h8000_03FF);
    rd("data", sec_pkg::REG_DATA, 32'h0, 32'hFFFF_FFFF);
    rd("unmapped", 4'h1, 32'h0, 32'hFFFF_FFFF);
    $display("test boot done");
    wr(sec_pkg::REG_DATA, 32'h5A);
    rd("data", sec_pkg::REG_DATA, 32'h5A, 32'hFFFF_FFFF);
    cmd(3'h2, 8'h10);
    chk("mem10", 48'h10, 48'(u_mem.mem[16]));
    cmd(3'h1, 8'h00);
    slow <= 1'b1;
    cmd(3'h2, 8'h10);
    chk("mem10", 48'h5A, 48'(u_mem.mem[16]));
    cmd(3'h4, 8'h10);
    chk("mem10", 48'hFF, 48'(u_mem.mem[16]));
    slow <= 1'b0;
    rd("cmd", sec_pkg::REG_CMD, 32'h10, 32'hFF);
    cmd(3'h0, 8'h00);
    cmd(3'h2, 8'h20);
    chk("mem20", 48'h20, 48'(u_mem.mem[32]));
    $display("test program done");
    cmd(3'h1, 8'h00);
    wr(sec_pkg::REG_CMD, 32'h200);
    wr(sec_pkg::REG_INT_STS, 32'h7);
    wr(sec_pkg::REG_INT_MASK, 32'h0);
    stuck <= 1'b1;
    cmd(3'h2, 8'h30);
    stuck <= 1'b0;
    rd("timeout", sec_pkg::REG_CMD, 32'h200, 32'h8000_0200);
    chk("irq", 48'h0, 48'(o_irq));
    wr(sec_pkg::REG_INT_MASK, 32'h2);
    rd("mask", sec_pkg::REG_INT_MASK, 32'h2, 32'h7);
    chk("irq", 48'h1, 48'(o_irq));
    wr(sec_pkg::REG_CMD, 32'h200);
    wr(sec_pkg::REG_INT_STS, 32'h2);
    rd("timeout", sec_pkg::REG_CMD, 32'h0, 32'h200);
    chk("irq", 48'h0, 48'(o_irq));
    $display("test timeout done");
    u_mem.mem[1] = 8'hC3;
    cmd(3'h7, 8'h00);
    chk("station", 48'h0605040302C3, o_station_addr);
    wr(sec_pkg::REG_DATA, 32'h3C);
    cmd(3'h3, 8'h40);
    for (int i = 0; i < 256; i += 85) chk("all", 48'h3C, 48'(u_mem.mem[i]));
    cmd(3'h5, 8'h80);
    for (int i = 0; i < 256; i += 85) chk("all", 48'hFF, 48'(u_mem.mem[i]));
    cmd(3'h7, 8'h00);
    chk("loaded", 48'h0, 48'(o_station_addr_loaded));
    $display("test bulk done");
    test_done();
  end
endmodule : test_sec_engine
